// file: logic/psp_regs.svh
// constants and timing counts of the burst sram port
// How it works
// - clock qualify high freezes command and pipeline state
// - all selects plus load start access
// - read data leaves output register next edge
// - drive data only while drive input low
// - new command accepted right after read
// - deselect tri-states outputs one edge later
// - burst counter serves four beats per address
// - order strap low linear, high interleaved
// - burst touches two low bits, wraps
// - advance steps counter, ignores selects
// - access type latched for whole burst
// - write command tri-states outputs next edge
// - write data sampled two edges after command
// - only selected byte lanes are written
// - sleep entry and exit take two cycles
// - sleep keeps contents, drops pending accesses
// - sleep request active high, idles low
// - floating order strap means interleaved
// - parity bit follows its lane select
// - power-up deselected with outputs tri-stated
`ifndef PSP_REGS_SVH
`define PSP_REGS_SVH

`define PSP_CLK_PERIOD_NS 25
`define PSP_SLEEP_ENTER_NS 50
`define PSP_SLEEP_RECOVER_NS 50
`define PSP_ENTER_CYC (`PSP_SLEEP_ENTER_NS / `PSP_CLK_PERIOD_NS)
`define PSP_RECOVER_CYC \
  ((`PSP_SLEEP_RECOVER_NS + `PSP_CLK_PERIOD_NS - 1) / `PSP_CLK_PERIOD_NS)

// synchroniser bits: 0 sleep, 1 drive_n, 2 burst order
`define PSP_SYNC_SLEEP_BIT 0
`define PSP_SYNC_DRIVE_BIT 1
`define PSP_SYNC_ORDER_BIT 2
`define PSP_SYNC_RST 3'h6

`endif

// file: logic/psp_pkg.sv
// types of the burst sram port
`default_nettype none
package psp_pkg;
  typedef enum logic [1:0] {
    PSP_RUN   = 2'b00,
    PSP_ENTER = 2'b01,
    PSP_SLEEP = 2'b10,
    PSP_EXIT  = 2'b11
  } psp_sleep_e;

  typedef logic [1:0] psp_beat_t;
endpackage
`default_nettype wire

// file: logic/psp_sram_port.sv
// pipelined burst sram port with sleep mode
`timescale 1ns/10ps
`default_nettype none
`include "psp_regs.svh"

module psp_sram_port #(
  parameter int ADDR_W = 18,
  parameter int DW     = 8,
  parameter int NB     = 4
) (
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  input  wire logic                clock_qualify_n,
  input  wire logic                chip_select_a_n,
  input  wire logic                chip_select_b,
  input  wire logic                chip_select_c_n,
  input  wire logic                advance_or_load,
  input  wire logic                write_enable_n,
  input  wire logic [NB-1:0]       byte_lane_write_n,
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [NB*DW-1:0]    data_in,
  input  wire logic [NB-1:0]       parity_in,
  input  wire logic                output_drive_n,
  input  wire logic                sleep_request,
  input  wire logic                burst_order,
  output logic      [NB*DW-1:0]    data_out,
  output logic      [NB-1:0]       parity_out,
  output logic                     data_oe
);
  import psp_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [1:0] ENTER_LAST = 2'(`PSP_ENTER_CYC - 1);
  localparam logic [1:0] RECOVER_LAST = 2'(`PSP_RECOVER_CYC - 1);

  // async pins: three stages, level moves when stages two and three agree
  logic [2:0] async_in;
  logic [2:0] meta_reg;
  logic [2:0] mid_reg;
  logic [2:0] late_reg;
  logic [2:0] lvl_reg;
  wire  [2:0] agree;
  wire  [2:0] lvl_next;

  assign async_in = {burst_order, output_drive_n, sleep_request};
  assign agree    = ~(mid_reg ^ late_reg);
  assign lvl_next = (agree & late_reg) | (~agree & lvl_reg);

  // reset levels: sleep low, drive off, strap high
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= `PSP_SYNC_RST;
      mid_reg  <= `PSP_SYNC_RST;
      late_reg <= `PSP_SYNC_RST;
      lvl_reg  <= `PSP_SYNC_RST;
    end else begin
      meta_reg <= async_in;
      mid_reg  <= meta_reg;
      late_reg <= mid_reg;
      lvl_reg  <= lvl_next;
    end
  end

  wire sleep_lvl = lvl_reg[`PSP_SYNC_SLEEP_BIT];
  wire drive_n_lvl = lvl_reg[`PSP_SYNC_DRIVE_BIT];
  wire order_lvl = lvl_reg[`PSP_SYNC_ORDER_BIT];

  // sleep sequencing
  psp_sleep_e st_reg;
  psp_sleep_e st_next;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;

  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      PSP_RUN: begin
        if (sleep_lvl) begin
          st_next  = PSP_ENTER;
          cnt_next = ENTER_LAST;
        end
      end
      PSP_ENTER: begin
        if (cnt_reg == 2'h0) begin
          st_next = PSP_SLEEP;
        end else begin
          cnt_next = cnt_reg - 2'h1;
        end
      end
      PSP_SLEEP: begin
        if (!sleep_lvl) begin
          st_next  = PSP_EXIT;
          cnt_next = RECOVER_LAST;
        end
      end
      PSP_EXIT: begin
        // commands stay ignored while recovering
        if (cnt_reg == 2'h0) begin
          st_next = PSP_RUN;
        end else begin
          cnt_next = cnt_reg - 2'h1;
        end
      end
      default: begin
        st_next  = PSP_RUN;
        cnt_next = 2'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg  <= PSP_RUN;
      cnt_reg <= 2'h0;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
    end
  end

  wire run = (st_reg == PSP_RUN);
  wire ce = ~clock_qualify_n & run;

  // command decode
  logic              active_reg;
  logic              burst_wr_reg;
  psp_beat_t         beat_reg;
  logic [ADDR_W-1:0] base_reg;

  wire sel = ~chip_select_a_n & chip_select_b & ~chip_select_c_n;
  wire load = ~advance_or_load;
  wire start = load & sel;
  wire stop = load & ~sel;
  wire step = advance_or_load & active_reg;
  wire [1:0] beat_next = beat_reg + 2'h1;
  wire [1:0] lin_lo = base_reg[1:0] + beat_next;
  wire [1:0] ilv_lo = base_reg[1:0] ^ beat_next;
  wire [1:0] burst_lo = order_lvl ? ilv_lo : lin_lo;
  wire op_valid = start | step;
  wire op_wr = start ? ~write_enable_n : burst_wr_reg;
  wire [ADDR_W-1:0] op_addr = start ? addr
                            : {base_reg[ADDR_W-1:2], burst_lo};

  // address only changes on load; advance keeps the latched type
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      active_reg   <= 1'b0;
      burst_wr_reg <= 1'b0;
      beat_reg     <= 2'h0;
      base_reg     <= '0;
    end else if (!run) begin
      active_reg <= 1'b0;
    end else if (ce) begin
      if (start) begin
        active_reg   <= 1'b1;
        burst_wr_reg <= ~write_enable_n;
        beat_reg     <= 2'h0;
        base_reg     <= addr;
      end else if (stop) begin
        active_reg <= 1'b0;
      end else if (step) begin
        beat_reg <= beat_next;
      end
    end
  end

  // pipeline: s1 one edge after command, s2 two edges after
  logic              s1_valid_reg;
  logic              s1_wr_reg;
  logic [ADDR_W-1:0] s1_addr_reg;
  logic [NB-1:0]     s1_bw_n_reg;
  logic              s2_valid_reg;
  logic [ADDR_W-1:0] s2_addr_reg;
  logic [NB-1:0]     s2_bw_n_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_valid_reg <= 1'b0;
      s1_wr_reg    <= 1'b0;
      s1_addr_reg  <= '0;
      s1_bw_n_reg  <= '1;
      s2_valid_reg <= 1'b0;
      s2_addr_reg  <= '0;
      s2_bw_n_reg  <= '1;
    end else if (!run) begin
      // pending accesses are dropped, contents kept
      s1_valid_reg <= 1'b0;
      s2_valid_reg <= 1'b0;
    end else if (ce) begin
      s1_valid_reg <= op_valid;
      s1_wr_reg    <= op_wr;
      s1_addr_reg  <= op_addr;
      s1_bw_n_reg  <= byte_lane_write_n;
      s2_valid_reg <= s1_valid_reg & s1_wr_reg;
      s2_addr_reg  <= s1_addr_reg;
      s2_bw_n_reg  <= s1_bw_n_reg;
    end
  end

  // storage per byte lane, parity bit travels with its lane
  wire wr_go = ce & s2_valid_reg;
  wire fwd = wr_go & (s2_addr_reg == s1_addr_reg);
  wire [NB*DW-1:0] rd_data;
  wire [NB-1:0]    rd_par;

  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_lane
      logic [DW:0] lane_mem [DEPTH];
      wire  [DW:0] lane_in = {parity_in[gi], data_in[gi*DW +: DW]};
      wire         lane_we = wr_go & ~s2_bw_n_reg[gi];
      // write then read of one word: forward the arriving lane
      wire  [DW:0] lane_rd = (fwd & ~s2_bw_n_reg[gi]) ? lane_in
                                                      : lane_mem[s1_addr_reg];

      assign rd_data[gi*DW +: DW] = lane_rd[DW-1:0];
      assign rd_par[gi]           = lane_rd[DW];

      // no reset here: contents must survive reset and sleep
      always_ff @(posedge clk_sys) begin
        if (lane_we) begin
          lane_mem[s2_addr_reg] <= lane_in;
        end
      end
    end
  endgenerate

  // output register and drive control
  logic             read_phase_reg;
  logic [NB*DW-1:0] data_q_reg;
  logic [NB-1:0]    par_q_reg;
  logic             oe_reg;

  wire s1_read = s1_valid_reg & ~s1_wr_reg;
  // write or deselect in s1 clears the read phase
  wire read_phase_next = !run ? 1'b0
                       : (ce ? s1_read : read_phase_reg);
  // drive pin is synchronised, so drive follows it five edges late
  wire oe_next = read_phase_next & ~drive_n_lvl;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      read_phase_reg <= 1'b0;
      data_q_reg     <= '0;
      par_q_reg      <= '0;
      oe_reg         <= 1'b0;
    end else begin
      read_phase_reg <= read_phase_next;
      oe_reg         <= oe_next;
      if (ce && s1_read) begin
        data_q_reg <= rd_data;
        par_q_reg  <= rd_par;
      end
    end
  end

  assign data_out   = data_q_reg;
  assign parity_out = par_q_reg;
  assign data_oe    = oe_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  a_stall_hold_state: assert property (
    (!ce && run && !sleep_lvl) |=>
      $stable({s1_valid_reg, s2_valid_reg, beat_reg, data_q_reg}))
    else $error("stalled edge changed pipeline state");

  a_read_drives_out: assert property (
    (ce && start && write_enable_n) ##1 (ce && !drive_n_lvl && !sleep_lvl)
      |=> data_oe && read_phase_reg)
    else $error("read did not drive data one edge later");

  a_drive_gated_pin: assert property (
    data_oe |-> $past(!drive_n_lvl) && read_phase_reg)
    else $error("data driven while drive input high");

  a_write_tristate: assert property (
    (ce && start && !write_enable_n) ##1 ce |=> !data_oe)
    else $error("outputs driven in write data phase");

  a_deselect_tristate: assert property (
    (ce && stop) ##1 ce |=> !data_oe)
    else $error("outputs driven after deselect");

  a_burst_type_held: assert property (
    (ce && start) ##1 (ce && step) |-> op_wr == $past(!write_enable_n))
    else $error("access type changed inside burst");

  a_order_interleave: assert property (
    (ce && start) ##1 (ce && step && order_lvl) |->
      op_addr[1:0] == ($past(addr[1:0]) ^ 2'h1))
    else $error("interleaved second beat address wrong");

  a_order_linear: assert property (
    (ce && start) ##1 (ce && step && !order_lvl) |->
      op_addr[1:0] == 2'($past(addr[1:0]) + 2'h1))
    else $error("linear second beat address wrong");

  a_write_commit: assert property (
    (ce && start && !write_enable_n && byte_lane_write_n == '0)
      ##1 (ce && run) ##1 (ce && run) |-> wr_go && s2_bw_n_reg == '0)
    else $error("write not committed two edges after command");

  a_sleep_entry: assert property (
    (run && sleep_lvl) |=> (st_reg == PSP_ENTER) [*2]
      ##1 st_reg == PSP_SLEEP)
    else $error("sleep entry did not take two cycles");

  a_sleep_exit: assert property (
    (st_reg == PSP_SLEEP && !sleep_lvl) |=> (st_reg == PSP_EXIT) [*2]
      ##1 st_reg == PSP_RUN)
    else $error("sleep exit did not take two cycles");

  a_sleep_quiet: assert property (
    !run |=> !data_oe && !s1_valid_reg && !s2_valid_reg)
    else $error("activity while asleep");

endmodule
`default_nettype wire

// file: tb/psp_ctrl_model.sv
// write data agent standing in for the memory controller
`timescale 1ns/10ps
`default_nettype none
module psp_ctrl_model (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        clock_qualify_n,
  input  wire logic        wr_issue,
  input  wire logic [35:0] wr_word,
  output logic      [31:0] data_in,
  output logic      [3:0]  parity_in
);
  logic [1:0]  pend_reg;
  logic [35:0] w1_reg;
  logic [35:0] w2_reg;
  logic [35:0] last_reg;
  // released bus shows the inverted last word, never a stale match
  assign {parity_in, data_in} = pend_reg[1] ? w2_reg : ~last_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pend_reg <= 2'h0;
      w1_reg   <= 36'h0;
      w2_reg   <= 36'h0;
      last_reg <= 36'h0;
    end else if (!clock_qualify_n) begin
      pend_reg <= {pend_reg[0], wr_issue};
      w1_reg   <= wr_word;
      w2_reg   <= w1_reg;
      last_reg <= pend_reg[1] ? w2_reg : last_reg;
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// testbench of the burst sram port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_sys, nrst, clock_qualify_n, advance_or_load, write_enable_n;
  logic chip_select_a_n, chip_select_b, chip_select_c_n;
  logic output_drive_n, sleep_request, burst_order, data_oe, wr_issue;
  logic [3:0] byte_lane_write_n, parity_in, parity_out;
  logic [5:0] addr, base;
  logic [31:0] data_in, data_out, seed;
  logic [35:0] wr_word;
  logic [35:0] mem [64];
  logic [35:0] exp_q [$];
  logic [1:0] bidx;
  logic bact, bwr, dead, mq;
  int fail_count, samples_checked;

  psp_sram_port #(.ADDR_W(6)) i_dut (.clk_sys(clk_sys), .nrst(nrst),
    .clock_qualify_n(clock_qualify_n), .chip_select_a_n(chip_select_a_n),
    .chip_select_b(chip_select_b), .chip_select_c_n(chip_select_c_n),
    .advance_or_load(advance_or_load), .write_enable_n(write_enable_n),
    .byte_lane_write_n(byte_lane_write_n), .addr(addr),
    .data_in(data_in), .parity_in(parity_in),
    .output_drive_n(output_drive_n), .sleep_request(sleep_request),
    .burst_order(burst_order), .data_out(data_out),
    .parity_out(parity_out), .data_oe(data_oe));
  psp_ctrl_model i_ctrl (.clk_sys(clk_sys), .nrst(nrst),
    .clock_qualify_n(clock_qualify_n), .wr_issue(wr_issue),
    .wr_word(wr_word), .data_in(data_in), .parity_in(parity_in));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cmp_w(input logic [35:0] g, input logic [35:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_b(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one command per edge; reference memory follows every accepted beat
  task automatic beat(input logic ld, input logic sl, input logic wn,
                      input logic [5:0] a, input logic [3:0] m);
    logic [35:0] w;
    logic [5:0] ea;
    logic acc;
    w[31:0] = rnd();
    w[35:32] = 4'(rnd());
    @(posedge clk_sys);
    advance_or_load <= ~ld;
    chip_select_a_n <= ~sl;
    chip_select_b <= sl;
    chip_select_c_n <= ~sl;
    write_enable_n <= wn;
    addr <= a;
    byte_lane_write_n <= m;
    clock_qualify_n <= 1'b0;
    acc = 1'b0;
    if (ld) begin
      bact = sl;
      base = a;
      bidx = 2'h0;
      bwr = ~wn;
      acc = sl;
    end else if (bact) begin
      bidx = bidx + 2'h1;
      acc = 1'b1;
    end
    ea = {base[5:2], burst_order ? base[1:0] ^ bidx : base[1:0] + bidx};
    wr_issue <= acc & bwr & ~dead;
    wr_word <= w;
    if (acc && !dead) begin
      if (bwr) begin
        for (int i = 0; i < 4; i++) begin
          if (!m[i]) begin
            mem[ea][8*i+:8] = w[8*i+:8];
            mem[ea][32+i] = w[32+i];
          end
        end
      end else if (!output_drive_n) exp_q.push_back(mem[ea]);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) beat(1'b1, 1'b0, 1'b1, 6'h00, 4'hF);
  endtask
  task automatic stall(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      clock_qualify_n <= 1'b1;
      advance_or_load <= 1'b0;
      chip_select_a_n <= 1'b0;
      chip_select_b <= 1'b1;
      chip_select_c_n <= 1'b0;
      wr_issue <= 1'b0;
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    mq = clock_qualify_n;
    #1;
    if (!mq && data_oe === 1'b1) begin
      if (exp_q.size() == 0) cmp_b(data_oe, 1'b0);
      else cmp_w({parity_out, data_out}, exp_q.pop_front());
    end
  end

  initial begin
    {nrst, clock_qualify_n, advance_or_load, write_enable_n} = 4'h0;
    {chip_select_a_n, chip_select_b, chip_select_c_n} = 3'b101;
    {output_drive_n, sleep_request, burst_order, wr_issue} = 4'h0;
    {byte_lane_write_n, addr, wr_word} = '1;
    {bact, bwr, dead, bidx, base} = '0;
    fail_count = 0;
    samples_checked = 0;
    seed = 32'h44;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    idle(6);
    #1;
    cmp_b(data_oe, 1'b0);
    cmp_w({parity_out, data_out}, 36'h0);
    for (int i = 0; i < 16; i++) begin
      beat(1'b1, 1'b1, 1'b0, i[5:0], 4'h0);
      beat(1'b1, 1'b1, 1'b1, i[5:0], 4'h0);
    end
    for (int m = 0; m < 16; m++) begin
      beat(1'b1, 1'b1, 1'b0, 6'h14, m[3:0]);
      beat(1'b1, 1'b1, 1'b1, 6'h14, 4'h0);
    end
    for (int o = 0; o < 2; o++) begin
      burst_order <= o[0];
      idle(6);
      for (int s = 0; s < 4; s++) begin
        beat(1'b1, 1'b1, 1'b0, 6'h20 + s[5:0], 4'h0);
        repeat (3) beat(1'b0, 1'b0, 1'b1, 6'h3F, 4'h0);
        beat(1'b1, 1'b1, 1'b1, 6'h20 + ((s[5:0] + 6'h1) & 6'h3), 4'h0);
        for (int k = 0; k < 4; k++) begin
          if (k == 2) stall(3);
          beat(1'b0, 1'b0, 1'b0, 6'h00, 4'h0);
        end
      end
    end
    beat(1'b1, 1'b1, 1'b1, 6'h03, 4'h0);
    beat(1'b1, 1'b1, 1'b0, 6'h05, 4'hA);
    beat(1'b1, 1'b0, 1'b1, 6'h00, 4'hF);
    @(posedge clk_sys);
    #1;
    cmp_b(data_oe, 1'b0);
    beat(1'b1, 1'b1, 1'b1, 6'h05, 4'h0);
    beat(1'b1, 1'b0, 1'b1, 6'h00, 4'hF);
    repeat (2) @(posedge clk_sys);
    #1;
    cmp_b(data_oe, 1'b0);
    output_drive_n <= 1'b1;
    idle(6);
    beat(1'b1, 1'b1, 1'b1, 6'h05, 4'h0);
    // look in the cycle where a read would be on the bus
    idle(2);
    #1;
    cmp_b(data_oe, 1'b0);
    idle(1);
    output_drive_n <= 1'b0;
    sleep_request <= 1'b1;
    idle(8);
    dead = 1'b1;
    beat(1'b1, 1'b1, 1'b0, 6'h01, 4'h0);
    idle(3);
    #1;
    cmp_b(data_oe, 1'b0);
    sleep_request <= 1'b0;
    idle(8);
    dead = 1'b0;
    for (int i = 0; i < 4; i++) beat(1'b1, 1'b1, 1'b1, i[5:0], 4'h0);
    idle(1);
    // advance with no open burst must stay a nop
    beat(1'b0, 1'b1, 1'b0, 6'h00, 4'h0);
    idle(4);
    if (exp_q.size() != 0) fail_count++;
    results();
  end
endmodule
`default_nettype wire
